/* File: rtl/ref_select_pll_control.v */
// Reference monitoring, selection, holdover and loop control logic.
`timescale 1ns/1ps
`default_nettype none
`include "ref_select_pll_control_defs.vh"

// Summary of operation
// - Any enabled monitor past its threshold flags loss of reference on that input.
// - In automatic mode loss on the selected input switches to another valid input; else, or in manual mode, holdover if locked or free run if not.
// - Each monitor threshold and enable is set separately per input.
// - Selection is automatic by priority and validity, or manual by software or pin.
// - Holdover starts from the averaged tuning word gathered while locked.
// - Digital loop: phase digitizer, loop filter, 40-bit fractional divider with modulator.
// - Fixed 40-bit denominator under loop control, else selectable 24-bit denominator.
// - Digital loop reference is an input or another analog loop's cascade output.
// - Analog loop reference is local oscillator input or another cascade output.
// - Digital loop steers the analog loop feedback numerator.
// - Post-divider of one bypasses the divider for the third oscillator.
// - Steered oscillator mode adjusts frequency finely by the step-up and step-down pins.
// - A step-up request adds the frequency step value, and a step-down request without a step-up in its cycle subtracts it.
// - With no valid reference and no prior lock the analog loop free-runs on the local oscillator.
module ref_select_pll_control #(
    parameter FREQ_WINDOW = 16'h1000
) (
    // Clock and reset
    input wire CLOCK,
    input wire SRST,
    // Register port
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // Reference inputs, sampled as synchronous levels
    input wire [1:0] REF_IN,
    input wire [1:0] REF_PPS_OK,
    // Pin controls
    input wire SEL_PIN,
    input wire STEP_UP_PIN,
    input wire STEP_DOWN_PIN,
    // Phase digitizer sample from the feedback clock comparison
    input wire [15:0] PHASE_ERR,
    input wire PHASE_VALID,
    // Loop outputs
    output reg [39:0] NUMERATOR,
    output reg [23:0] DEN24,
    output reg DEN24_USE,
    output reg SDM_OUT,
    output reg REF_SEL,
    output reg HOLDOVER,
    output reg FREE_RUN,
    output reg [1:0] LOSS_OF_REFERENCE,
    output reg [1:0] DIG_REF_MUX,
    output reg ANA_REF_MUX,
    output reg POST_DIV_BYPASS
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    reg [7:0] ctrl;
    reg [1:0] prio;
    reg [9:0] mon_en;
    reg [15:0] freq_lim [0:1];
    reg [15:0] gap_lim [0:1];
    reg [1:0] loss_event;
    reg [39:0] step;
    reg [2:0] mux;
    reg [3:0] gain;
    reg [39:0] hist;
    reg [39:0] nominal;
    reg [39:0] accum;
    reg locked;
    reg [15:0] win_cnt;
    reg [1:0] step_up_d;
    wire [1:0] lor_now;
    wire win_end;

    assign win_end = (win_cnt == FREQ_WINDOW);

    // Frequency window timer shared by both inputs.
    always @(posedge CLOCK) begin
        if (SRST || win_end) begin
            win_cnt <= 16'h0000;
        end else begin
            win_cnt <= win_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Per-input monitors
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : mon
            reg prev;
            reg [15:0] edges;
            reg [15:0] gap;
            reg [15:0] last_edges;
            reg [15:0] high_len;
            reg runt;
            reg early;
            wire rise;
            wire fall;
            wire [4:0] en;
            wire freq_bad;
            wire miss_bad;
            assign rise = REF_IN[gi] & ~prev;
            assign fall = ~REF_IN[gi] & prev;
            assign en = mon_en[gi*5 +: 5];
            assign freq_bad = (last_edges > freq_lim[gi]) ||
                (last_edges < (freq_lim[gi] >> 1));
            assign miss_bad = gap > gap_lim[gi];
            assign lor_now[gi] = (en[`MON_FREQ] & freq_bad) |
                (en[`MON_MISS] & miss_bad) |
                (en[`MON_EARLY] & early) |
                (en[`MON_RUNT] & runt) |
                (en[`MON_PPS] & ~REF_PPS_OK[gi]);
            // Edge counting, gap timing and pulse width checks.
            always @(posedge CLOCK) begin
                if (SRST) begin
                    prev <= 1'b0;
                    edges <= 16'h0000;
                    last_edges <= 16'h0000;
                    gap <= 16'h0000;
                    high_len <= 16'h0000;
                    runt <= 1'b0;
                    early <= 1'b0;
                end else begin
                    prev <= REF_IN[gi];
                    if (win_end) begin
                        last_edges <= edges;
                        edges <= {15'h0000, rise};
                    end else if (rise) begin
                        edges <= edges + 16'h0001;
                    end
                    if (rise) begin
                        gap <= 16'h0000;
                        early <= gap < (gap_lim[gi] >> 2);
                    end else if (gap != 16'hFFFF) begin
                        gap <= gap + 16'h0001;
                    end
                    if (REF_IN[gi]) begin
                        high_len <= high_len + 16'h0001;
                    end else begin
                        high_len <= 16'h0000;
                    end
                    // A high phase sampled on only one edge counts as a runt.
                    if (fall) begin
                        runt <= high_len == 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Selection, holdover and loss flags
    // ------------------------------------------------------------
    reg next_sel;
    always @* begin
        if (ctrl[`CTRL_MANUAL]) begin
            next_sel = ctrl[`CTRL_PIN_SEL_EN] ? SEL_PIN : ctrl[`CTRL_MAN_SEL];
        end else if (!LOSS_OF_REFERENCE[prio[0]]) begin
            next_sel = prio[0];
        end else if (!LOSS_OF_REFERENCE[prio[1]]) begin
            next_sel = prio[1];
        end else begin
            next_sel = REF_SEL;
        end
    end

    // Latches status, switches input and enters holdover.
    always @(posedge CLOCK) begin
        if (SRST) begin
            LOSS_OF_REFERENCE <= 2'b11;
            REF_SEL <= 1'b0;
            HOLDOVER <= 1'b0;
            FREE_RUN <= 1'b1;
        end else begin
            LOSS_OF_REFERENCE <= lor_now;
            REF_SEL <= next_sel;
            HOLDOVER <= LOSS_OF_REFERENCE[next_sel] & locked;
            FREE_RUN <= LOSS_OF_REFERENCE[next_sel] & ~locked;
        end
    end

    // ------------------------------------------------------------
    // Digital loop: filter, numerator, history, modulator
    // ------------------------------------------------------------
    wire [39:0] err_ext;
    wire [39:0] hist_step;
    wire step_req_up;
    wire step_req_dn;
    assign err_ext = {{24{PHASE_ERR[15]}}, PHASE_ERR};
    assign hist_step = ($signed(NUMERATOR) - $signed(hist)) >>> `HIST_SHIFT;
    assign step_req_up = STEP_UP_PIN & ~step_up_d[0];
    assign step_req_dn = STEP_DOWN_PIN & ~step_up_d[1];

    // Loop filter, numerator steering, history and sigma-delta modulator.
    always @(posedge CLOCK) begin
        if (SRST) begin
            NUMERATOR <= 40'h0000000000;
            hist <= 40'h0000000000;
            accum <= 40'h0000000000;
            SDM_OUT <= 1'b0;
            locked <= 1'b0;
            step_up_d <= 2'b00;
        end else begin
            step_up_d <= {STEP_DOWN_PIN, STEP_UP_PIN};
            {SDM_OUT, accum} <= {1'b0, accum} + {1'b0, NUMERATOR};
            if (!ctrl[`CTRL_LOOP_EN] || FREE_RUN) begin
                NUMERATOR <= nominal;
                locked <= 1'b0;
            end else if (HOLDOVER) begin
                NUMERATOR <= hist;
            end else if (ctrl[`CTRL_STEER_EN]) begin
                if (step_req_up) begin
                    NUMERATOR <= NUMERATOR + step;
                end else if (step_req_dn) begin
                    NUMERATOR <= NUMERATOR - step;
                end
            end else if (PHASE_VALID) begin
                NUMERATOR <= NUMERATOR + (err_ext <<< gain);
                locked <= 1'b1;
                hist <= hist + hist_step;
            end
        end
    end

    // ------------------------------------------------------------
    // Mux, denominator and post-divider outputs
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (SRST) begin
            DIG_REF_MUX <= 2'b00;
            ANA_REF_MUX <= 1'b0;
            DEN24_USE <= 1'b0;
            POST_DIV_BYPASS <= 1'b0;
        end else begin
            DIG_REF_MUX <= mux[1] ? 2'b10 : {1'b0, REF_SEL};
            ANA_REF_MUX <= mux[2];
            DEN24_USE <= ctrl[`CTRL_DEN24_SEL] & ~ctrl[`CTRL_LOOP_EN];
            POST_DIV_BYPASS <= ctrl[`CTRL_POST_DIV1];
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always @(posedge CLOCK) begin
        if (SRST) begin
            ctrl <= `CTRL_RESET;
            prio <= 2'b10;
            mon_en <= `MON_EN_RESET;
            freq_lim[0] <= `FREQ_LIM_RESET;
            freq_lim[1] <= `FREQ_LIM_RESET;
            gap_lim[0] <= `GAP_LIM_RESET;
            gap_lim[1] <= `GAP_LIM_RESET;
            step <= 40'h0000000001;
            nominal <= 40'h0000000000;
            DEN24 <= 24'h000001;
            mux <= 3'h0;
            gain <= `GAIN_RESET;
            loss_event <= 2'b00;
            RDATA <= 32'h00000000;
        end else begin
            if (WR && ADDR == `REG_EVENT) begin
                loss_event <= (loss_event & ~WDATA[1:0]) | lor_now;
            end else begin
                loss_event <= loss_event | lor_now;
            end
            if (WR) begin
                case (ADDR)
                    `REG_CTRL: ctrl <= WDATA[7:0];
                    `REG_PRIO: prio <= {~WDATA[0], WDATA[0]};
                    `REG_MON_EN: mon_en <= WDATA[9:0];
                    `REG_FREQ_LIM0: freq_lim[0] <= WDATA[15:0];
                    `REG_FREQ_LIM1: freq_lim[1] <= WDATA[15:0];
                    `REG_GAP_LIM0: gap_lim[0] <= WDATA[15:0];
                    `REG_GAP_LIM1: gap_lim[1] <= WDATA[15:0];
                    `REG_STEP_LO: step[31:0] <= WDATA;
                    `REG_STEP_HI: step[39:32] <= WDATA[7:0];
                    `REG_NUM_LO: nominal[31:0] <= WDATA;
                    `REG_NUM_HI: nominal[39:32] <= WDATA[7:0];
                    `REG_DEN24: DEN24 <= WDATA[23:0];
                    `REG_MUX: mux <= WDATA[2:0];
                    `REG_GAIN: gain <= WDATA[3:0];
                    default: ;
                endcase
            end
            if (RD) begin
                case (ADDR)
                    `REG_CTRL: RDATA <= {24'h000000, ctrl};
                    `REG_PRIO: RDATA <= {31'h00000000, prio[0]};
                    `REG_MON_EN: RDATA <= {22'h000000, mon_en};
                    `REG_FREQ_LIM0: RDATA <= {16'h0000, freq_lim[0]};
                    `REG_FREQ_LIM1: RDATA <= {16'h0000, freq_lim[1]};
                    `REG_GAP_LIM0: RDATA <= {16'h0000, gap_lim[0]};
                    `REG_GAP_LIM1: RDATA <= {16'h0000, gap_lim[1]};
                    `REG_STATUS: RDATA <= {26'h0000000, locked, FREE_RUN,
                        HOLDOVER, REF_SEL, LOSS_OF_REFERENCE};
                    `REG_EVENT: RDATA <= {30'h00000000, loss_event};
                    `REG_STEP_LO: RDATA <= step[31:0];
                    `REG_STEP_HI: RDATA <= {24'h000000, step[39:32]};
                    `REG_NUM_LO: RDATA <= NUMERATOR[31:0];
                    `REG_NUM_HI: RDATA <= {24'h000000, NUMERATOR[39:32]};
                    `REG_HIST: RDATA <= hist[39:8];
                    `REG_DEN24: RDATA <= {8'h00, DEN24};
                    `REG_MUX: RDATA <= {29'h00000000, mux};
                    `REG_GAIN: RDATA <= {28'h0000000, gain};
                    default: RDATA <= 32'h00000000;
                endcase
            end else begin
                RDATA <= 32'h00000000;
            end
        end
    end

endmodule // ref_select_pll_control

`default_nettype wire

/* File: inc/ref_select_pll_control_defs.vh */
// Constants for the reference selection and loop control block.
`ifndef REF_SELECT_PLL_CONTROL_DEFS_VH
`define REF_SELECT_PLL_CONTROL_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_PRIO 8'h04
`define REG_MON_EN 8'h08
`define REG_FREQ_LIM0 8'h0C
`define REG_FREQ_LIM1 8'h10
`define REG_GAP_LIM0 8'h14
`define REG_GAP_LIM1 8'h18
`define REG_STATUS 8'h1C
`define REG_EVENT 8'h20
`define REG_STEP_LO 8'h24
`define REG_STEP_HI 8'h28
`define REG_NUM_LO 8'h2C
`define REG_NUM_HI 8'h30
`define REG_HIST 8'h34
`define REG_DEN24 8'h38
`define REG_MUX 8'h3C
`define REG_GAIN 8'h40

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_MANUAL 0
`define CTRL_MAN_SEL 1
`define CTRL_PIN_SEL_EN 2
`define CTRL_LOOP_EN 3
`define CTRL_STEER_EN 4
`define CTRL_DEN24_SEL 5
`define CTRL_POST_DIV1 6

// ----------------------------------------------------------------
// Monitor enable fields, five per input
// ----------------------------------------------------------------
`define MON_FREQ 0
`define MON_MISS 1
`define MON_EARLY 2
`define MON_RUNT 3
`define MON_PPS 4
`define MON_PER_INPUT 5

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define CTRL_RESET 8'h08
`define MON_EN_RESET 10'h3FF
`define FREQ_LIM_RESET 16'h0100
`define GAP_LIM_RESET 16'h0040
`define GAIN_RESET 4'h4
`define FRAC_WIDTH 40
`define DEN24_WIDTH 24
`define HIST_SHIFT 4

`endif

/* File: sim/ref_select_pll_control_properties.sv */
// Port-level checks for the reference selection and loop control block.
`timescale 1ns/1ps
`default_nettype none
`include "ref_select_pll_control_defs.vh"
module ref_select_pll_control_properties #(
    parameter FREQ_WINDOW = 16'h1000
) (
    // Clock, reset and register port
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic [7:0] ADDR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // Loop and selection state
    input wire logic [39:0] NUMERATOR,
    input wire logic SDM_OUT,
    input wire logic REF_SEL,
    input wire logic HOLDOVER,
    input wire logic FREE_RUN,
    input wire logic [1:0] LOSS_OF_REFERENCE,
    input wire logic [1:0] DIG_REF_MUX
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // ----------------------------------------------------------------
    // Sequences
    // ----------------------------------------------------------------
    // A status read and the answer that mirrors the state it sampled.
    sequence status_read;
        RD && ADDR == `REG_STATUS;
    endsequence
    sequence status_answer;
        RDATA[4:0] == {$past(FREE_RUN), $past(HOLDOVER), $past(REF_SEL),
            $past(LOSS_OF_REFERENCE)};
    endsequence
    // Both inputs have been lost for three cycles in a row.
    sequence no_ref;
        LOSS_OF_REFERENCE == 2'h3 [*3];
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // reset free run
    a_reset_state: assert property (disable iff (1'b0)
        SRST |=> LOSS_OF_REFERENCE == 2'h3 && FREE_RUN && !HOLDOVER
        && NUMERATOR == 40'h0) else $error("Reset state is wrong.");
    a_status_mirror: assert property (status_read |=> status_answer)
        else $error("Status read does not match the loop state.");
    a_unmapped_zero: assert property (RD && ADDR == 8'hFC |=>
        RDATA == 32'h0) else $error("Unmapped read is not zero.");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("Read data shown without a read.");
    a_holdover_cause: assert property ($rose(HOLDOVER) |->
        LOSS_OF_REFERENCE[REF_SEL]) else $error("Holdover without loss.");
    a_no_ref_mode: assert property (no_ref |-> FREE_RUN || HOLDOVER)
        else $error("No fallback mode while both inputs are lost.");
    a_modes_exclusive: assert property (!(HOLDOVER && FREE_RUN))
        else $error("Holdover and free run at once.");
    a_dig_mux_range: assert property (DIG_REF_MUX != 2'h3)
        else $error("Digital loop mux has an unused code.");
    a_sdm_quiet: assert property (NUMERATOR == 40'h0 [*8] |->
        !SDM_OUT) else $error("Modulator carry with a zero numerator.");
endmodule // ref_select_pll_control_properties
bind ref_select_pll_control ref_select_pll_control_properties #(
    .FREQ_WINDOW(FREQ_WINDOW)
) u_props (.CLOCK(CLOCK), .SRST(SRST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
    .NUMERATOR(NUMERATOR), .SDM_OUT(SDM_OUT), .REF_SEL(REF_SEL),
    .HOLDOVER(HOLDOVER), .FREE_RUN(FREE_RUN),
    .LOSS_OF_REFERENCE(LOSS_OF_REFERENCE), .DIG_REF_MUX(DIG_REF_MUX));
`default_nettype wire

/* File: sim/ref_clock_source.sv */
// Behavioural model of the two reference clock sources.
`timescale 1ns/1ps
`default_nettype none
module ref_clock_source #(
    parameter HALF = 4
) (
    // Clock and source run controls
    input wire logic CLOCK,
    input wire logic [1:0] run,
    // Reference levels and pulse-per-second health
    output var logic [1:0] ref_out,
    output var logic [1:0] pps_ok
);
    integer cnt = 0;
    // Paces both references; a larger HALF gives a slower source.
    always @(posedge CLOCK) begin
        cnt <= (cnt + 1) % (2 * HALF);
    end
    // A stopped source holds its line low, so no edges reach the monitors.
    always @* begin
        ref_out[0] = run[0] && (cnt < HALF);
        ref_out[1] = run[1] && (cnt >= HALF);
        pps_ok = run;
    end
endmodule // ref_clock_source
`default_nettype wire

/* File: sim/tb_ref_select_pll_control.sv */
// Self-checking bench for the reference selection and loop control block.
`timescale 1ns/1ps
`default_nettype none
`include "ref_select_pll_control_defs.vh"
module tb_ref_select_pll_control;
    logic CLOCK, SRST, WR, RD, SEL_PIN, STEP_UP_PIN, STEP_DOWN_PIN;
    logic PHASE_VALID, DEN24_USE, SDM_OUT, REF_SEL, HOLDOVER, FREE_RUN;
    logic ANA_REF_MUX, POST_DIV_BYPASS;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, rv;
    logic [15:0] PHASE_ERR;
    logic [39:0] NUMERATOR;
    logic [23:0] DEN24;
    logic [1:0] REF_IN, REF_PPS_OK, LOSS_OF_REFERENCE, DIG_REF_MUX, run;
    integer n_errors = 0;
    integer checks_done = 0;
    integer i;
    // ----------------------------------------------------------------
    // Design, sources and clock
    // ----------------------------------------------------------------
    ref_select_pll_control #(.FREQ_WINDOW(16'h0040)) DUT (.CLOCK(CLOCK),
        .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .REF_IN(REF_IN), .REF_PPS_OK(REF_PPS_OK),
        .SEL_PIN(SEL_PIN), .STEP_UP_PIN(STEP_UP_PIN),
        .STEP_DOWN_PIN(STEP_DOWN_PIN), .PHASE_ERR(PHASE_ERR),
        .PHASE_VALID(PHASE_VALID), .NUMERATOR(NUMERATOR), .DEN24(DEN24),
        .DEN24_USE(DEN24_USE), .SDM_OUT(SDM_OUT), .REF_SEL(REF_SEL),
        .HOLDOVER(HOLDOVER), .FREE_RUN(FREE_RUN),
        .LOSS_OF_REFERENCE(LOSS_OF_REFERENCE), .DIG_REF_MUX(DIG_REF_MUX),
        .ANA_REF_MUX(ANA_REF_MUX), .POST_DIV_BYPASS(POST_DIV_BYPASS));
    ref_clock_source #(.HALF(4)) SRC (.CLOCK(CLOCK), .run(run),
        .ref_out(REF_IN), .pps_ok(REF_PPS_OK));
    // Free-running system clock of 10 ns.
    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    // Compares a value and counts any mismatch.
    task chk(input string what, input [39:0] seen, input [39:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then stops.
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Lets n edges pass, then steps past the edge updates.
    task idle(input integer n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    // One-cycle register write.
    task wr(input [7:0] a, input [31:0] d);
        @(posedge CLOCK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask
    // One-cycle read; data is taken in the cycle after the strobe only.
    task rd(input [7:0] a);
        @(posedge CLOCK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        rv = RDATA;
    endtask
    // Bounded wait for a loss pattern and holdover level.
    task wait_state(input [1:0] e_loss, input e_hold);
        for (i = 0; i < 800 && (LOSS_OF_REFERENCE !== e_loss ||
            HOLDOVER !== e_hold); i = i + 1) begin
            @(posedge CLOCK);
            #1;
        end
        chk("loss", {LOSS_OF_REFERENCE, HOLDOVER}, {e_loss, e_hold});
        if (i == 800) begin
            n_errors = n_errors + 1;
            end_of_test();
        end
    endtask
    // One adjustment pulse on a step pin.
    task step(input up);
        @(posedge CLOCK);
        STEP_UP_PIN <= up;
        STEP_DOWN_PIN <= !up;
        repeat (2) @(posedge CLOCK);
        STEP_UP_PIN <= 1'b0;
        STEP_DOWN_PIN <= 1'b0;
        idle(3);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset state at the ports and in the register table.
    task t_reset;
        static logic [7:0] ra [5] = '{`REG_CTRL, `REG_MON_EN,
            `REG_FREQ_LIM0, `REG_GAP_LIM1, `REG_GAIN};
        static logic [31:0] rs [5] = '{32'h08, 32'h3FF, 32'h100, 32'h40,
            32'h4};
        @(posedge CLOCK);
        SRST <= 1'b1;
        repeat (2) @(posedge CLOCK);
        SRST <= 1'b0;
        #1;
        chk("free run", {FREE_RUN, HOLDOVER, DEN24}, {2'h2, 24'h1});
        chk("numerator", NUMERATOR, 40'h0);
        for (int k = 0; k < 5; k++) begin
            rd(ra[k]);
            chk("reset reg", rv, rs[k]);
        end
        wr(`REG_STATUS, 32'h1F);
        rd(8'hFC);
        chk("unmapped", rv, 32'h0);
    endtask
    // Monitors, per-input enables and automatic switchover.
    task t_monitor;
        wr(`REG_GAP_LIM0, 32'h10);
        wr(`REG_GAP_LIM1, 32'h10);
        wr(`REG_MON_EN, 32'h3DE);
        run <= 2'h3;
        wait_state(2'h0, 1'b0);
        chk("auto sel", REF_SEL, 1'b0);
        wr(`REG_EVENT, 32'h3);
        @(posedge CLOCK);
        run <= 2'h2;
        wait_state(2'h1, 1'b0);
        idle(3);
        chk("switch", REF_SEL, 1'b1);
        rd(`REG_EVENT);
        chk("event", rv[1:0], 2'h1);
        wr(`REG_EVENT, 32'h3);
        wr(`REG_MON_EN, 32'h3C0);
        wait_state(2'h0, 1'b0);
        wr(`REG_MON_EN, 32'h3DE);
        run <= 2'h3;
    endtask
    // Manual selection by software and by the pin.
    task t_manual;
        static logic [7:0] ctl [4] = '{8'h09, 8'h0B, 8'h0D, 8'h0D};
        for (int k = 0; k < 4; k++) begin
            @(posedge CLOCK);
            SEL_PIN <= (k == 2);
            wr(`REG_CTRL, {24'h0, ctl[k]});
            idle(3);
            chk("manual sel", REF_SEL, (k == 1 || k == 2));
        end
        wr(`REG_CTRL, 32'h08);
    endtask
    // Step requests move the numerator across the 32-bit word boundary.
    task t_steer;
        wr(`REG_CTRL, 32'h10);
        wr(`REG_STEP_LO, 32'h5);
        wr(`REG_STEP_HI, 32'h0);
        wr(`REG_NUM_LO, 32'hFFFFFFFE);
        wr(`REG_NUM_HI, 32'h0);
        idle(3);
        chk("nominal", NUMERATOR, 40'h00FFFFFFFE);
        // Steering acts only while the loop is enabled.
        wr(`REG_CTRL, 32'h18);
        step(1'b1);
        chk("step up", NUMERATOR, 40'h0100000003);
        step(1'b0);
        step(1'b0);
        chk("step down", NUMERATOR, 40'h00FFFFFFF9);
        rd(`REG_NUM_LO);
        chk("live num", rv, 32'hFFFFFFF9);
    endtask
    // Denominator choice, post-divider bypass and reference muxes.
    task t_config;
        wr(`REG_CTRL, 32'h20);
        wr(`REG_DEN24, 32'h0ABCDE);
        idle(3);
        chk("den24", {DEN24_USE, DEN24}, {1'b1, 24'h0ABCDE});
        wr(`REG_CTRL, 32'h68);
        idle(3);
        chk("den40", {DEN24_USE, POST_DIV_BYPASS}, 2'h1);
        wr(`REG_MUX, 32'h2);
        idle(3);
        chk("dig mux", {DIG_REF_MUX, ANA_REF_MUX}, 3'h4);
        wr(`REG_MUX, 32'h4);
        idle(3);
        chk("ana mux", ANA_REF_MUX, 1'b1);
        wr(`REG_MUX, 32'h0);
        wr(`REG_CTRL, 32'h08);
    endtask
    // Lock, then lose both inputs and enter holdover from the history.
    task t_holdover;
        PHASE_ERR <= 16'h0;
        PHASE_VALID <= 1'b1;
        idle(100);
        @(posedge CLOCK);
        PHASE_VALID <= 1'b0;
        rd(`REG_STATUS);
        chk("locked", rv[5], 1'b1);
        @(posedge CLOCK);
        run <= 2'h0;
        wait_state(2'h3, 1'b1);
        chk("no free run", FREE_RUN, 1'b0);
        rd(`REG_HIST);
        chk("history", NUMERATOR[39:8], rv);
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {SRST, WR, RD, SEL_PIN, STEP_UP_PIN, STEP_DOWN_PIN} = 6'h20;
        {PHASE_VALID, ADDR, WDATA, PHASE_ERR, run} = '0;
        t_reset();
        t_monitor();
        t_manual();
        t_steer();
        t_config();
        t_holdover();
        t_reset();
        end_of_test();
    end
endmodule // tb_ref_select_pll_control
`default_nettype wire
